// [pced_pkg.sv]
// Package: register map, reset values and widths for the pin change block
package pced_pkg;
  localparam int PCED_AW = 4;
  localparam int PCED_DW = 8;
  localparam logic [3:0] PCED_A_RISE_ADDR = 4'h0;
  localparam logic [3:0] PCED_A_FALL_ADDR = 4'h1;
  localparam logic [3:0] PCED_A_FLAG_ADDR = 4'h2;
  localparam logic [3:0] PCED_B_RISE_ADDR = 4'h3;
  localparam logic [3:0] PCED_B_FALL_ADDR = 4'h4;
  localparam logic [3:0] PCED_B_FLAG_ADDR = 4'h5;
  localparam logic [3:0] PCED_CTRL_ADDR = 4'h6;
  localparam logic [3:0] PCED_STAT_ADDR = 4'h7;
  localparam logic [7:0] PCED_REG_RST = 8'h00;
  localparam logic [7:0] PCED_B_IMPL_MASK = 8'hf0;
  localparam logic [7:0] PCED_A_SMALL_MASK = 8'h3f;
  localparam logic [7:0] PCED_A_DBG_MASK = 8'hfc;
  localparam int PCED_CTRL_IRQ_EN_BIT = 0;
  localparam int PCED_STAT_SUM_BIT = 0;
endpackage : pced_pkg

// [pced_edge_cell.sv]
// One port's edge detectors and sticky change flags
`timescale 1ns/1ps
`default_nettype none
module pced_edge_cell
  import pced_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] rise_en_in,
  input wire logic [WIDTH-1:0] fall_en_in,
  input wire logic [WIDTH-1:0] impl_mask_in,
  input wire logic flag_wr_in,
  input wire logic [WIDTH-1:0] flag_wdata_in,
  output logic [WIDTH-1:0] flag_out
);
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] prev_nxt;
  logic [WIDTH-1:0] flag_r;
  logic [WIDTH-1:0] flag_nxt;
  logic [WIDTH-1:0] hit;
  logic [WIDTH-1:0] seen_r;

  always_comb begin
    prev_nxt = pin_in;
    // Compare with the previous sample so one transition is one event
    hit = ((pin_in & ~prev_r & rise_en_in) |
           (~pin_in & prev_r & fall_en_in)) & impl_mask_in;
    flag_nxt = flag_r;
    if (flag_wr_in) begin
      flag_nxt = flag_wdata_in & impl_mask_in;
    end
    // Edge set wins over the software write in the same cycle
    flag_nxt = flag_nxt | hit;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prev_r <= '0;
      flag_r <= '0;
      seen_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      flag_r <= flag_nxt;
      seen_r <= hit;
    end
  end

  assign flag_out = flag_r;

  flag_sticks_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    |seen_r |-> ((flag_r & seen_r) == seen_r))
    else $error("Detected edge did not set its flag");
endmodule : pced_edge_cell
`default_nettype wire

// [pced_top.sv]
// Top: registers, two ports of edge detection, summary flag and interrupt
//
// What this block does
// - Port A falling edge with its enable set sets pin flag and summary.
// - A cleared edge enable never sets a flag for that direction.
// - Port A flag sets on enabled rising or enabled falling edge.
// - Flags are hardware set, software readable, writable and clearable.
// - All enables and flags reset to zero on every reset.
// - Port A pins 1 and 0 are unusable while the debugger is on.
// - Port B pins 7:4 rising edge, when enabled, sets flag and summary.
// - Port B pins 7:4 falling edge, when enabled, sets flag and summary.
// - Port B bits 3:0 are unimplemented and read zero.
// - Port B flags 7:4 are hardware set and software read/write.
// - Summary flag is set whenever any per-pin flag is set.
// - Detection runs regardless; interrupt only when its enable is set.
// - An edge during a clearing write leaves the flag set.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pced_top
  import pced_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic debug_en_in,
  input wire logic [7:0] porta_pin_in,
  input wire logic [7:0] portb_pin_in,
  input wire logic [PCED_AW-1:0] addr_in,
  input wire logic [PCED_DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [PCED_DW-1:0] rdata_out,
  output logic irq_out
);
  logic [7:0] porta_rise_en_r;
  logic [7:0] porta_rise_en_nxt;
  logic [7:0] porta_fall_en_r;
  logic [7:0] porta_fall_en_nxt;
  logic [7:0] portb_rise_en_r;
  logic [7:0] portb_rise_en_nxt;
  logic [7:0] portb_fall_en_r;
  logic [7:0] portb_fall_en_nxt;
  logic change_irq_en_r;
  logic change_irq_en_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [7:0] porta_change_flag;
  logic [7:0] portb_change_flag;
  logic [7:0] porta_mask;
  logic [7:0] portb_mask;
  logic change_summary_flag;
  logic wr_a_flag;
  logic wr_b_flag;

  // Variant trims port A top bits and all of port B; debugger takes A[1:0]
  always_comb begin
    porta_mask = LARGE_VARIANT ? 8'hff : PCED_A_SMALL_MASK;
    if (debug_en_in) begin
      porta_mask = porta_mask & PCED_A_DBG_MASK;
    end
    portb_mask = LARGE_VARIANT ? PCED_B_IMPL_MASK : 8'h00;
  end

  assign wr_a_flag = wr_in && (addr_in == PCED_A_FLAG_ADDR);
  assign wr_b_flag = wr_in && (addr_in == PCED_B_FLAG_ADDR);

  always_comb begin
    porta_rise_en_nxt = porta_rise_en_r;
    porta_fall_en_nxt = porta_fall_en_r;
    portb_rise_en_nxt = portb_rise_en_r;
    portb_fall_en_nxt = portb_fall_en_r;
    change_irq_en_nxt = change_irq_en_r;
    if (wr_in && addr_in == PCED_A_RISE_ADDR) begin
      porta_rise_en_nxt = wdata_in & porta_mask;
    end else if (wr_in && addr_in == PCED_A_FALL_ADDR) begin
      porta_fall_en_nxt = wdata_in & porta_mask;
    end else if (wr_in && addr_in == PCED_B_RISE_ADDR) begin
      portb_rise_en_nxt = wdata_in & portb_mask;
    end else if (wr_in && addr_in == PCED_B_FALL_ADDR) begin
      portb_fall_en_nxt = wdata_in & portb_mask;
    end else if (wr_in && addr_in == PCED_CTRL_ADDR) begin
      change_irq_en_nxt = wdata_in[PCED_CTRL_IRQ_EN_BIT];
    end
  end

  pced_edge_cell #(.WIDTH(8)) u_porta (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .pin_in(porta_pin_in),
    .rise_en_in(porta_rise_en_r),
    .fall_en_in(porta_fall_en_r),
    .impl_mask_in(porta_mask),
    .flag_wr_in(wr_a_flag),
    .flag_wdata_in(wdata_in),
    .flag_out(porta_change_flag)
  );

  pced_edge_cell #(.WIDTH(8)) u_portb (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .pin_in(portb_pin_in),
    .rise_en_in(portb_rise_en_r),
    .fall_en_in(portb_fall_en_r),
    .impl_mask_in(portb_mask),
    .flag_wr_in(wr_b_flag),
    .flag_wdata_in(wdata_in),
    .flag_out(portb_change_flag)
  );

  // Summary is live, not stored, so it can never disagree with the flags
  assign change_summary_flag = |{porta_change_flag, portb_change_flag};

  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in && addr_in == PCED_A_RISE_ADDR) begin
      rdata_nxt = porta_rise_en_r;
    end else if (rd_in && addr_in == PCED_A_FALL_ADDR) begin
      rdata_nxt = porta_fall_en_r;
    end else if (rd_in && addr_in == PCED_A_FLAG_ADDR) begin
      rdata_nxt = porta_change_flag;
    end else if (rd_in && addr_in == PCED_B_RISE_ADDR) begin
      rdata_nxt = portb_rise_en_r & portb_mask;
    end else if (rd_in && addr_in == PCED_B_FALL_ADDR) begin
      rdata_nxt = portb_fall_en_r & portb_mask;
    end else if (rd_in && addr_in == PCED_B_FLAG_ADDR) begin
      rdata_nxt = portb_change_flag & portb_mask;
    end else if (rd_in && addr_in == PCED_CTRL_ADDR) begin
      rdata_nxt[PCED_CTRL_IRQ_EN_BIT] = change_irq_en_r;
    end else if (rd_in && addr_in == PCED_STAT_ADDR) begin
      rdata_nxt[PCED_STAT_SUM_BIT] = change_summary_flag;
    end
    // Flags keep detecting even with the interrupt masked
    irq_nxt = change_summary_flag & change_irq_en_r;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      porta_rise_en_r <= PCED_REG_RST;
      porta_fall_en_r <= PCED_REG_RST;
      portb_rise_en_r <= PCED_REG_RST;
      portb_fall_en_r <= PCED_REG_RST;
      change_irq_en_r <= 1'b0;
    end else begin
      porta_rise_en_r <= porta_rise_en_nxt;
      porta_fall_en_r <= porta_fall_en_nxt;
      portb_rise_en_r <= portb_rise_en_nxt;
      portb_fall_en_r <= portb_fall_en_nxt;
      change_irq_en_r <= change_irq_en_nxt;
    end
  end

  // Read data stand one cycle only; idle reads return zero, not stale data
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Registered so the pin is glitch free, at the cost of one cycle of lag
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign irq_out = irq_r;

  // Edges are judged against the pin one cycle back; that cycle must be
  // out of reset, since the sample register restarts at zero
  a_fall_sets_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (porta_fall_en_r[2] && !porta_pin_in[2] && $past(porta_pin_in[2])
     && !$past(srst_in))
    |=> porta_change_flag[2])
    else $error("Port A falling edge did not set flag");

  a_rise_sets_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (porta_rise_en_r[3] && porta_pin_in[3] && !$past(porta_pin_in[3])
     && !$past(srst_in))
    |=> porta_change_flag[3] ##0 change_summary_flag)
    else $error("Port A rising edge did not set flag");

  a_dir_gate_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (!porta_rise_en_r[7] && porta_pin_in[7] && !$past(porta_pin_in[7])
     && !porta_change_flag[7] && !wr_a_flag)
    |=> !porta_change_flag[7])
    else $error("Rising edge set flag without its enable");

  b_rise_sets_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (portb_rise_en_r[4] && portb_pin_in[4] && !$past(portb_pin_in[4])
     && !$past(srst_in) && LARGE_VARIANT)
    |=> portb_change_flag[4] ##0 change_summary_flag)
    else $error("Port B rising edge did not set flag");

  b_fall_sets_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (portb_fall_en_r[5] && !portb_pin_in[5] && $past(portb_pin_in[5])
     && !$past(srst_in) && LARGE_VARIANT)
    |=> portb_change_flag[5] ##0 change_summary_flag)
    else $error("Port B falling edge did not set flag");

  no_en_no_set_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (porta_rise_en_r == 8'h00 && porta_fall_en_r == 8'h00 && !wr_a_flag)
    |=> porta_change_flag == $past(porta_change_flag))
    else $error("Flag set with edges disabled");

  b_no_en_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (portb_rise_en_r == 8'h00 && portb_fall_en_r == 8'h00 && !wr_b_flag)
    |=> portb_change_flag == $past(portb_change_flag))
    else $error("Port B flag set with edges disabled");

  b_low_zero_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    rd_in && (addr_in == PCED_B_FLAG_ADDR || addr_in == PCED_B_RISE_ADDR)
    |=> rdata_out[3:0] == 4'h0)
    else $error("Port B low bits not zero");

  b_impl_bits_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    portb_rise_en_r[3:0] == 4'h0 && portb_fall_en_r[3:0] == 4'h0
    && portb_change_flag[3:0] == 4'h0)
    else $error("Port B unimplemented bits hold state");

  irq_gate_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    ##1 irq_out == $past(change_summary_flag && change_irq_en_r))
    else $error("Interrupt not gated by its enable");

  irq_off_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !change_irq_en_r |=> !irq_out)
    else $error("Interrupt raised while disabled");

  reset_clear_a: assert property (
    @(posedge clk_in)
    $past(srst_in) |-> porta_change_flag == 8'h00 && irq_out == 1'b0)
    else $error("Reset left state set");

  reset_en_a: assert property (
    @(posedge clk_in)
    $past(srst_in) |-> porta_rise_en_r == 8'h00 && porta_fall_en_r == 8'h00
    && portb_rise_en_r == 8'h00 && portb_fall_en_r == 8'h00
    && portb_change_flag == 8'h00 && !change_irq_en_r)
    else $error("Reset left an enable or flag set");

  flag_clear_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_a_flag && wdata_in == 8'h00 && porta_pin_in == $past(porta_pin_in)
    && !$past(srst_in) |=> porta_change_flag == 8'h00)
    else $error("Software clear did not take");

  flag_write_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_a_flag && porta_pin_in == $past(porta_pin_in) && !$past(srst_in)
    |=> porta_change_flag == $past(wdata_in & porta_mask))
    else $error("Flag write did not land");

  flag_hold_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !wr_a_flag
    |=> (porta_change_flag & $past(porta_change_flag))
    == $past(porta_change_flag))
    else $error("Port A flag dropped without a write");

  b_hold_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !wr_b_flag
    |=> (portb_change_flag & $past(portb_change_flag))
    == $past(portb_change_flag))
    else $error("Port B flag dropped without a write");

  summary_read_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == PCED_STAT_ADDR
    |=> rdata_out == {7'h00, $past(porta_change_flag != 8'h00
                                  || portb_change_flag != 8'h00)})
    else $error("Summary flag does not follow pin flags");

  race_set_wins_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (wr_b_flag && wdata_in == 8'h00 && portb_rise_en_r[6]
     && portb_pin_in[6] && !$past(portb_pin_in[6]) && !$past(srst_in)
     && LARGE_VARIANT)
    |=> portb_change_flag[6])
    else $error("Clearing write lost a detected edge");

  pin_steady_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    porta_pin_in == $past(porta_pin_in) && !$past(srst_in) && !wr_a_flag
    |=> porta_change_flag == $past(porta_change_flag))
    else $error("Flag set without a pin transition");

  dbg_bits_a: assert property (
    @(posedge clk_in) disable iff (srst_in)
    debug_en_in && $past(debug_en_in) && !$past(srst_in)
    |-> ##1 (porta_change_flag[1:0] & ~$past(porta_change_flag[1:0]))
    == 2'b00)
    else $error("Debug pins raised a flag");
endmodule : pced_top
`default_nettype wire

// [pced_pin_model.sv]
// Pin model: external levels on port A and port B pins
`timescale 1ns/1ps
`default_nettype none
module pced_pin_model (
  input wire logic clk_in,
  output logic [7:0] porta_pin_out,
  output logic [7:0] portb_pin_out
);
  initial begin
    porta_pin_out = 8'h00;
    portb_pin_out = 8'h00;
  end
  // Levels move only right after an edge, so each change is one clean step
  task automatic drive(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_in);
    porta_pin_out <= a;
    portb_pin_out <= b;
  endtask : drive
endmodule : pced_pin_model
`default_nettype wire

// [pced_top_bench.sv]
// Bench: register, edge, summary and interrupt checks of the pin change top
`timescale 1ns/1ps
`default_nettype none
module pced_top_bench
  import pced_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic dbg = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] pa;
  logic [7:0] pb;
  int fails = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  pced_pin_model i_pced_pin_model (.clk_in(clk), .porta_pin_out(pa),
    .portb_pin_out(pb));
  pced_top i_pced_top (.clk_in(clk), .srst_in(srst), .debug_en_in(dbg),
    .porta_pin_in(pa), .portb_pin_in(pb), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq));
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check($sformatf("reg %0h", a), rdata, exp);
  endtask : rd_chk
  // Pin change lands as a flag one edge later, irq one edge after that
  task automatic pins(input logic [7:0] a, input logic [7:0] b);
    i_pced_pin_model.drive(a, b);
    repeat (3) @(posedge clk);
  endtask : pins
  task automatic t_reset();
    for (int i = 0; i < 9; i++) rd_chk(i[3:0], 8'h00);
    check("irq", {7'h00, irq}, 8'h00);
  endtask : t_reset
  task automatic t_porta();
    wr_reg(PCED_A_RISE_ADDR, 8'h0f);
    wr_reg(PCED_A_FALL_ADDR, 8'hf4);
    pins(8'hff, 8'h00);
    rd_chk(PCED_A_FLAG_ADDR, 8'h0f);
    rd_chk(PCED_STAT_ADDR, 8'h01);
    check("irq", {7'h00, irq}, 8'h00);
    wr_reg(PCED_CTRL_ADDR, 8'h01);
    @(posedge clk);
    @(negedge clk);
    check("irq", {7'h00, irq}, 8'h01);
    rd_chk(PCED_CTRL_ADDR, 8'h01);
    wr_reg(PCED_A_FLAG_ADDR, 8'h0f & ~8'h0f);
    rd_chk(PCED_A_FLAG_ADDR, 8'h00);
    rd_chk(PCED_STAT_ADDR, 8'h00);
    check("irq", {7'h00, irq}, 8'h00);
    pins(8'h00, 8'h00);
    rd_chk(PCED_A_FLAG_ADDR, 8'hf4);
    check("irq", {7'h00, irq}, 8'h01);
    wr_reg(PCED_A_FLAG_ADDR, 8'h24);
    rd_chk(PCED_A_FLAG_ADDR, 8'h24);
  endtask : t_porta
  task automatic t_portb();
    wr_reg(PCED_B_RISE_ADDR, 8'hff);
    rd_chk(PCED_B_RISE_ADDR, 8'hf0);
    wr_reg(PCED_B_FALL_ADDR, 8'h30);
    rd_chk(PCED_B_FALL_ADDR, 8'h30);
    pins(8'h00, 8'hff);
    rd_chk(PCED_B_FLAG_ADDR, 8'hf0);
    wr_reg(PCED_B_FLAG_ADDR, 8'h00);
    pins(8'h00, 8'h00);
    rd_chk(PCED_B_FLAG_ADDR, 8'h30);
  endtask : t_portb
  // Clearing write lands on the same edge as the hardware set
  task automatic t_race();
    wr_reg(PCED_B_FLAG_ADDR, 8'h00);
    i_pced_pin_model.drive(8'h00, 8'hff);
    wr <= 1'b1;
    addr <= PCED_B_FLAG_ADDR;
    wdata <= 8'h00;
    @(posedge clk);
    wr <= 1'b0;
    rd_chk(PCED_B_FLAG_ADDR, 8'hf0);
  endtask : t_race
  task automatic t_debug();
    @(posedge clk);
    dbg <= 1'b1;
    wr_reg(PCED_A_FLAG_ADDR, 8'h00);
    pins(8'h0f, 8'h00);
    rd_chk(PCED_A_FLAG_ADDR, 8'h0c);
    wr_reg(PCED_A_RISE_ADDR, 8'hff);
    rd_chk(PCED_A_RISE_ADDR, 8'hfc);
    @(posedge clk);
    dbg <= 1'b0;
  endtask : t_debug
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_porta();
    t_portb();
    t_race();
    t_debug();
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    final_report();
  end
endmodule : pced_top_bench
`default_nettype wire
